// *** pkg/embedded_block_memory_pkg.sv ***
package embedded_block_memory_pkg;

  localparam int          DATA_W     = 9;
  localparam int          ADDR_W     = 10;
  localparam int          CNT_W      = 11;
  localparam int          MEM_DEPTH  = 1024;
  localparam int          APB_AW     = 8;

  // Register byte offsets.
  localparam logic [7:0]  OFS_CONFIG = 8'h00;
  localparam logic [7:0]  OFS_FULL   = 8'h04;
  localparam logic [7:0]  OFS_AFULL  = 8'h08;
  localparam logic [7:0]  OFS_AEMPTY = 8'h0C;
  localparam logic [7:0]  OFS_STATUS = 8'h10;

  // Configuration and status field positions.
  localparam int          CFG_W        = 10;
  localparam int          CFG_MODE_LSB = 0;
  localparam int          CFG_WB_LSB   = 2;
  localparam int          CFG_WSEL_LSB = 4;
  localparam int          CFG_RSEL_LSB = 7;
  localparam int          STAT_CNT_LSB = 16;

  // Reset values and threshold limits.
  localparam logic [9:0]  CFG_RST      = 10'h3F0;
  localparam logic [9:0]  FULL_RST     = 10'h3FF;
  localparam logic [9:0]  AFULL_RST    = 10'h3FE;
  localparam logic [9:0]  AEMPTY_RST   = 10'h001;
  localparam logic [9:0]  THR_MIN      = 10'h001;
  localparam logic [9:0]  THR_MAX      = 10'h3FF;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_DUAL   = 2'b01,
    MODE_PSEUDO = 2'b10,
    MODE_QUEUE  = 2'b11
  } mem_mode_t;

  typedef enum logic [1:0] {
    WB_NORMAL     = 2'b00,
    WB_THROUGH    = 2'b01,
    WB_READ_FIRST = 2'b10
  } wr_behave_t;

endpackage

// *** rtl/embedded_block_memory.sv ***
`timescale 1ns/1ps
// Block memory with RAM modes and a queue mode, configured over APB.
module embedded_block_memory
  import embedded_block_memory_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  input  wire logic              a_select,
  input  wire logic              a_clock_enable,
  input  wire logic              a_write_enable,
  input  wire logic [ADDR_W-1:0] a_address,
  input  wire logic [DATA_W-1:0] a_write_data,
  output logic      [DATA_W-1:0] a_read_data,
  input  wire logic              b_select,
  input  wire logic              b_clock_enable,
  input  wire logic              b_write_enable,
  input  wire logic [ADDR_W-1:0] b_address,
  input  wire logic [DATA_W-1:0] b_write_data,
  output logic      [DATA_W-1:0] b_read_data,
  input  wire logic              write_port_clock,
  input  wire logic [1:0]        write_port_select,
  input  wire logic              full_cascade_in,
  input  wire logic              write_clock_enable,
  input  wire logic              write_enable,
  input  wire logic [DATA_W-1:0] queue_write_data,
  input  wire logic              read_port_clock,
  input  wire logic [1:0]        read_port_select,
  input  wire logic              empty_cascade_in,
  input  wire logic              read_clock_enable,
  input  wire logic              read_strobe,
  output logic      [DATA_W-1:0] queue_read_data,
  input  wire logic              queue_reset,
  input  wire logic              read_pointer_clear,
  output logic                   full_flag,
  output logic                   near_full_flag,
  output logic                   empty_flag,
  output logic                   near_empty_flag
);

  // The storage: 1024 words of 9 bits.
  logic [DATA_W-1:0] mem_array [MEM_DEPTH];

  logic [CFG_W-1:0]  cfg_reg,     cfg_next;
  logic [ADDR_W-1:0] full_thr_reg, full_thr_next;
  logic [ADDR_W-1:0] afull_reg,   afull_next;
  logic [ADDR_W-1:0] aempty_reg,  aempty_next;
  logic              pready_reg,  pready_next;
  logic [31:0]       prdata_reg,  prdata_next;
  logic              pslverr_reg, pslverr_next;

  mem_mode_t         mode;
  wr_behave_t        behave;
  logic [2:0]        wsel_code;
  logic [2:0]        rsel_code;

  logic              wclk_prev_reg, rclk_prev_reg;
  logic              wclk_rise, rclk_rise;
  logic [CNT_W-1:0]  wr_ptr_reg, wr_ptr_next;
  logic [CNT_W-1:0]  rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0]  count, count_next;
  logic              full_reg, full_next;
  logic              nfull_reg, nfull_next;
  logic              empty_reg, empty_next;
  logic              nempty_reg, nempty_next;
  logic [DATA_W-1:0] qdata_reg, qdata_next;
  logic              queue_mode, wsel_hit, rsel_hit;
  logic              wr_accept, rd_accept;

  logic [ADDR_W-1:0] a_stg_addr, b_stg_addr;
  logic [DATA_W-1:0] a_stg_din, b_stg_din;
  logic              a_stg_wr, b_stg_wr;

  // Clamp a threshold write into its legal range.
  function automatic logic [ADDR_W-1:0] clamp_thr(input logic [31:0]       v,
                                                   input logic [ADDR_W-1:0] hi);
    logic [ADDR_W-1:0] r;
    r = v[ADDR_W-1:0];
    if (v[31:ADDR_W] != '0 || r > hi) begin
      r = hi;
    end
    if (r < THR_MIN) begin
      r = THR_MIN;
    end
    return r;
  endfunction

  // Configuration field decode.
  always_comb begin
    mode      = mem_mode_t'(cfg_reg[CFG_MODE_LSB +: 2]);
    behave    = wr_behave_t'(cfg_reg[CFG_WB_LSB +: 2]);
    wsel_code = cfg_reg[CFG_WSEL_LSB +: 3];
    rsel_code = cfg_reg[CFG_RSEL_LSB +: 3];
  end

  // APB slave with one wait state so that every bus output comes from a flop.
  // Writes land at the edge where pready is seen high, as the bus expects.
  always_comb begin
    cfg_next      = cfg_reg;
    full_thr_next = full_thr_reg;
    afull_next    = afull_reg;
    aempty_next   = aempty_reg;
    pready_next   = psel & penable & ~pready_reg;
    prdata_next   = 32'h0000_0000;
    pslverr_next  = 1'b0;
    if (psel && penable && !pready_reg) begin
      case (paddr)
        OFS_CONFIG: prdata_next = {{(32-CFG_W){1'b0}}, cfg_reg};
        OFS_FULL:   prdata_next = {{(32-ADDR_W){1'b0}}, full_thr_reg};
        OFS_AFULL:  prdata_next = {{(32-ADDR_W){1'b0}}, afull_reg};
        OFS_AEMPTY: prdata_next = {{(32-ADDR_W){1'b0}}, aempty_reg};
        OFS_STATUS: begin
          prdata_next[STAT_CNT_LSB +: CNT_W] = count;
          prdata_next[3:0] = {nempty_reg, empty_reg, nfull_reg, full_reg};
        end
        default:    pslverr_next = 1'b1;
      endcase
    end
    if (psel && penable && pready_reg && pwrite) begin
      case (paddr)
        OFS_CONFIG: cfg_next      = pwdata[CFG_W-1:0];
        OFS_FULL:   full_thr_next = clamp_thr(pwdata, THR_MAX);
        OFS_AFULL:  afull_next    = clamp_thr(pwdata, full_thr_reg - THR_MIN);
        OFS_AEMPTY: aempty_next   = clamp_thr(pwdata, full_thr_reg - THR_MIN);
        default:    cfg_next      = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg      <= CFG_RST;
      full_thr_reg <= FULL_RST;
      afull_reg    <= AFULL_RST;
      aempty_reg   <= AEMPTY_RST;
      pready_reg   <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
      pslverr_reg  <= 1'b0;
    end else begin
      cfg_reg      <= cfg_next;
      full_thr_reg <= full_thr_next;
      afull_reg    <= afull_next;
      aempty_reg   <= aempty_next;
      pready_reg   <= pready_next;
      prdata_reg   <= prdata_next;
      pslverr_reg  <= pslverr_next;
    end
  end

  // Queue port decode; the port clocks are sampled, so only their rising edges count.
  always_comb begin
    queue_mode = (mode == MODE_QUEUE);
    wclk_rise  = write_port_clock & ~wclk_prev_reg;
    rclk_rise  = read_port_clock & ~rclk_prev_reg;
    wsel_hit   = ({full_cascade_in, write_port_select} == wsel_code);
    rsel_hit   = ({empty_cascade_in, read_port_select} == rsel_code);
    count      = wr_ptr_reg - rd_ptr_reg;
    wr_accept  = queue_mode & wclk_rise & wsel_hit & write_clock_enable & write_enable
                 & (count < {1'b0, full_thr_reg});
    rd_accept  = queue_mode & rclk_rise & rsel_hit & read_clock_enable & read_strobe
                 & (count != '0);
  end

  // Pointers, flags and the read data register of the queue.
  always_comb begin
    wr_ptr_next = wr_ptr_reg + {{(CNT_W-1){1'b0}}, wr_accept};
    rd_ptr_next = rd_ptr_reg + {{(CNT_W-1){1'b0}}, rd_accept};
    qdata_next  = rd_accept ? mem_array[rd_ptr_reg[ADDR_W-1:0]] : qdata_reg;
    if (read_pointer_clear) begin
      rd_ptr_next = '0;
    end
    if (queue_reset) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
    end
    count_next  = wr_ptr_next - rd_ptr_next;
    full_next   = full_reg;
    nfull_next  = nfull_reg;
    empty_next  = empty_reg;
    nempty_next = nempty_reg;
    if (wclk_rise) begin
      full_next  = (count_next >= {1'b0, full_thr_reg});
      nfull_next = (count_next >= {1'b0, afull_reg});
    end
    if (rclk_rise) begin
      empty_next  = (count_next == '0);
      nempty_next = (count_next <= {1'b0, aempty_reg});
    end
    if (queue_reset) begin
      full_next   = 1'b0;
      nfull_next  = 1'b0;
      empty_next  = 1'b1;
      nempty_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wclk_prev_reg <= 1'b0;
      rclk_prev_reg <= 1'b0;
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      full_reg      <= 1'b0;
      nfull_reg     <= 1'b0;
      empty_reg     <= 1'b1;
      nempty_reg    <= 1'b1;
      qdata_reg     <= '0;
    end else begin
      wclk_prev_reg <= write_port_clock;
      rclk_prev_reg <= read_port_clock;
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      full_reg      <= full_next;
      nfull_reg     <= nfull_next;
      empty_reg     <= empty_next;
      nempty_reg    <= nempty_next;
      qdata_reg     <= qdata_next;
    end
  end

  // Port A serves every RAM mode; port B only the two dual modes.
  memory_port_stage u_port_a (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .port_en   (!queue_mode),
    .wr_allow  (1'b1),
    .rd_allow  (mode != MODE_PSEUDO),
    .behave    (behave),
    .sel       (a_select),
    .ce        (a_clock_enable),
    .we        (a_write_enable),
    .addr      (a_address),
    .din       (a_write_data),
    .mem_rdata (mem_array[a_stg_addr]),
    .stg_addr  (a_stg_addr),
    .stg_din   (a_stg_din),
    .stg_wr    (a_stg_wr),
    .dout      (a_read_data)
  );

  memory_port_stage u_port_b (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .port_en   (mode == MODE_DUAL || mode == MODE_PSEUDO),
    .wr_allow  (mode == MODE_DUAL),
    .rd_allow  (1'b1),
    .behave    (behave),
    .sel       (b_select),
    .ce        (b_clock_enable),
    .we        (b_write_enable),
    .addr      (b_address),
    .din       (b_write_data),
    .mem_rdata (mem_array[b_stg_addr]),
    .stg_addr  (b_stg_addr),
    .stg_din   (b_stg_din),
    .stg_wr    (b_stg_wr),
    .dout      (b_read_data)
  );

  // Array writes; the array is not reset, so its contents survive a queue reset.
  // Same-address writes from A and B in one cycle are resolved in favour of B.
  always_ff @(posedge sys_clk) begin
    if (a_stg_wr) begin
      mem_array[a_stg_addr] <= a_stg_din;
    end
    if (b_stg_wr) begin
      mem_array[b_stg_addr] <= b_stg_din;
    end
    if (wr_accept) begin
      mem_array[wr_ptr_reg[ADDR_W-1:0]] <= queue_write_data;
    end
  end

  assign pready          = pready_reg;
  assign prdata          = prdata_reg;
  assign pslverr         = pslverr_reg;
  assign queue_read_data = qdata_reg;
  assign full_flag       = full_reg;
  assign near_full_flag  = nfull_reg;
  assign empty_flag      = empty_reg;
  assign near_empty_flag = nempty_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  full_on_wclk_a: assert property (!wclk_rise && !queue_reset |=>
    $stable({full_reg, nfull_reg}))
    else $error("Full flags moved without a write clock edge.");
  empty_on_rclk_a: assert property (!rclk_rise && !queue_reset |=>
    $stable({empty_reg, nempty_reg}))
    else $error("Empty flags moved without a read clock edge.");
  empty_level_a: assert property (rclk_rise && !queue_reset |=> empty_reg == (count == '0))
    else $error("Empty flag disagrees with zero occupancy.");
  full_level_a: assert property (wclk_rise && !queue_reset |=>
    full_reg == (count >= {1'b0, full_thr_reg}))
    else $error("Full flag disagrees with threshold.");
  queue_clear_a: assert property (queue_reset |=> count == '0 && empty_reg && !full_reg)
    else $error("Queue reset left data or flags.");
  rp_clear_a: assert property (read_pointer_clear && !queue_reset |=>
    rd_ptr_reg == '0 && wr_ptr_reg == $past(wr_ptr_next))
    else $error("Read pointer clear misbehaved.");
  // Checked against the raw configuration word so that a broken select decode shows up.
  cascade_sel_a: assert property (wr_accept |->
    {full_cascade_in, write_port_select} == cfg_reg[CFG_WSEL_LSB +: 3]
    && count < {1'b0, full_thr_reg})
    else $error("Write taken with wrong cascade select or when full.");
  no_ptr_move_a: assert property (!(rclk_rise && read_clock_enable && rsel_hit)
    && !read_pointer_clear && !queue_reset |=> $stable(rd_ptr_reg))
    else $error("Read pointer moved without a taken read.");
  apb_answer_a: assert property (psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("APB answer timing broken.");

  cover_full_c: cover property (queue_mode && full_reg);
  cover_drain_c: cover property (rd_accept ##[1:50] empty_reg);
  cover_err_c: cover property (pslverr_reg);

endmodule // embedded_block_memory

// *** rtl/memory_port_stage.sv ***
`timescale 1ns/1ps
// One RAM port: input register stage, then output register with write behaviour.
module memory_port_stage
  import embedded_block_memory_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              port_en,
  input  wire logic              wr_allow,
  input  wire logic              rd_allow,
  input  wire wr_behave_t        behave,
  input  wire logic              sel,
  input  wire logic              ce,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic [DATA_W-1:0] mem_rdata,
  output logic      [ADDR_W-1:0] stg_addr,
  output logic      [DATA_W-1:0] stg_din,
  output logic                   stg_wr,
  output logic      [DATA_W-1:0] dout
);

  logic              stg_wr_reg, stg_wr_next;
  logic              stg_rd_reg, stg_rd_next;
  logic [ADDR_W-1:0] addr_reg,   addr_next;
  logic [DATA_W-1:0] din_reg,    din_next;
  logic [DATA_W-1:0] dout_reg,   dout_next;

  // Input stage captures only while selected and clock enabled.
  always_comb begin
    stg_wr_next = 1'b0;
    stg_rd_next = 1'b0;
    addr_next   = addr_reg;
    din_next    = din_reg;
    if (port_en && sel && ce) begin
      stg_wr_next = we & wr_allow;
      stg_rd_next = ~we & rd_allow;
      addr_next   = addr;
      din_next    = din;
    end
  end

  // Output stage; the stored word is read before the array takes the write.
  always_comb begin
    dout_next = dout_reg;
    if (stg_rd_reg) begin
      dout_next = mem_rdata;
    end else if (stg_wr_reg) begin
      case (behave)
        WB_THROUGH:    dout_next = din_reg;
        WB_READ_FIRST: dout_next = mem_rdata;
        default:       dout_next = dout_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stg_wr_reg <= 1'b0;
      stg_rd_reg <= 1'b0;
      addr_reg   <= '0;
      din_reg    <= '0;
      dout_reg   <= '0;
    end else begin
      stg_wr_reg <= stg_wr_next;
      stg_rd_reg <= stg_rd_next;
      addr_reg   <= addr_next;
      din_reg    <= din_next;
      dout_reg   <= dout_next;
    end
  end

  assign stg_addr = addr_reg;
  assign stg_din  = din_reg;
  assign stg_wr   = stg_wr_reg;
  assign dout     = dout_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  port_ignore_a: assert property (!(port_en && sel && ce) |=> !stg_wr_reg && !stg_rd_reg)
    else $error("Port captured a request while idle.");
  normal_hold_a: assert property (stg_wr_reg && behave == WB_NORMAL |=> $stable(dout_reg))
    else $error("Normal write changed the output.");
  write_thru_a: assert property (stg_wr_reg && behave == WB_THROUGH |=>
    dout_reg == $past(din_reg))
    else $error("Write-through output differs from written word.");
  read_first_a: assert property (stg_wr_reg && behave == WB_READ_FIRST |=>
    dout_reg == $past(mem_rdata))
    else $error("Read-before-write output is not the old word.");
  cover_thru_c: cover property (stg_wr_reg && behave == WB_THROUGH);

endmodule // memory_port_stage

// *** tb/embedded_block_memory_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench: registers over APB, RAM write behaviours and queue mode.
module embedded_block_memory_tb import embedded_block_memory_pkg::*;;
  logic              sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              a_select, a_clock_enable, a_write_enable;
  logic              b_select, b_clock_enable, b_write_enable;
  logic [ADDR_W-1:0] a_address, b_address;
  logic [DATA_W-1:0] a_write_data, b_write_data, a_read_data, b_read_data;
  logic              write_port_clock, full_cascade_in, write_clock_enable, write_enable;
  logic              read_port_clock, empty_cascade_in, read_clock_enable, read_strobe;
  logic [1:0]        write_port_select, read_port_select;
  logic [DATA_W-1:0] queue_write_data, queue_read_data;
  logic              queue_reset, read_pointer_clear;
  logic              full_flag, near_full_flag, empty_flag, near_empty_flag;
  int                miscompares, cmp_count, cycles;

  embedded_block_memory u_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .a_select, .a_clock_enable, .a_write_enable, .a_address,
    .a_write_data, .a_read_data, .b_select, .b_clock_enable, .b_write_enable, .b_address,
    .b_write_data, .b_read_data, .write_port_clock, .write_port_select, .full_cascade_in,
    .write_clock_enable, .write_enable, .queue_write_data, .read_port_clock,
    .read_port_select, .empty_cascade_in, .read_clock_enable, .read_strobe,
    .queue_read_data, .queue_reset, .read_pointer_clear, .full_flag, .near_full_flag,
    .empty_flag, .near_empty_flag);

  queue_user_model u_user (.sys_clk, .write_port_clock, .write_clock_enable, .write_enable,
    .queue_write_data, .read_port_clock, .read_clock_enable, .read_strobe, .queue_read_data);

  // Free-running 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;

  // Hang guard: the full run needs well under two thousand cycles.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // APB transfer; the request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No wait count is assumed; only the hang guard ends a missing answer.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q, exp);
  endtask

  task automatic occ_chk(input logic [10:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    check("occupancy", 32'(q[26:16]), 32'(exp));
  endtask

  // One RAM request on port A or B; returns once read data has had two edges to land.
  task automatic ram(input logic p, input logic s, input logic c, input logic w,
                     input logic [9:0] ad, input logic [8:0] d);
    @(posedge sys_clk);
    if (p) begin
      {b_select, b_clock_enable, b_write_enable, b_address, b_write_data} <= {s, c, w, ad, d};
    end else begin
      {a_select, a_clock_enable, a_write_enable, a_address, a_write_data} <= {s, c, w, ad, d};
    end
    @(posedge sys_clk);
    a_select <= 1'b0;
    b_select <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd_chk("config", OFS_CONFIG, 32'h0000_03F0);
    rd_chk("full thr", OFS_FULL, 32'h0000_03FF);
    rd_chk("afull thr", OFS_AFULL, 32'h0000_03FE);
    rd_chk("aempty thr", OFS_AEMPTY, 32'h0000_0001);
    rd_chk("status", OFS_STATUS, 32'h0000_000C);
    apb(1'b0, 8'h14, 32'h0, q, e);
    check("unmapped err", 32'(e), 32'h1);
    check("unmapped data", q, 32'h0);
    reg_wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk("status ro", OFS_STATUS, 32'h0000_000C);
  endtask

  // Each write behaviour: the prior read shows 033, then a write to address 5.
  task automatic t_ram();
    logic [8:0] old;
    logic [8:0] nv;
    ram(1'b0, 1'b1, 1'b1, 1'b1, 10'h005, 9'h0AA);
    ram(1'b0, 1'b1, 1'b1, 1'b1, 10'h006, 9'h033);
    ram(1'b0, 1'b0, 1'b1, 1'b1, 10'h006, 9'h1FF);
    ram(1'b0, 1'b1, 1'b0, 1'b1, 10'h006, 9'h1FF);
    old = 9'h0AA;
    for (int b = 0; b < 4; b++) begin
      nv = 9'h100 | 9'(b);
      reg_wr(OFS_CONFIG, 32'h3F0 | 32'(b << CFG_WB_LSB));
      ram(1'b0, 1'b1, 1'b1, 1'b0, 10'h006, 9'h000);
      check("ignored write", 32'(a_read_data), 32'h033);
      ram(1'b0, 1'b1, 1'b1, 1'b1, 10'h005, nv);
      check("write out", 32'(a_read_data),
            32'((b == 1) ? nv : (b == 2) ? old : 9'h033));
      ram(1'b0, 1'b1, 1'b1, 1'b0, 10'h005, 9'h000);
      check("read back", 32'(a_read_data), 32'(nv));
      old = nv;
    end
    reg_wr(OFS_CONFIG, 32'h3F1);
    ram(1'b1, 1'b1, 1'b1, 1'b0, 10'h005, 9'h000);
    check("port b read", 32'(b_read_data), 32'(old));
    // Pseudo dual: port A may only write and port B may only read.
    reg_wr(OFS_CONFIG, 32'h3F2);
    ram(1'b0, 1'b1, 1'b1, 1'b1, 10'h006, 9'h077);
    ram(1'b0, 1'b1, 1'b1, 1'b0, 10'h006, 9'h000);
    check("pseudo a read", 32'(a_read_data), 32'(old));
    ram(1'b1, 1'b1, 1'b1, 1'b1, 10'h006, 9'h1EE);
    ram(1'b1, 1'b1, 1'b1, 1'b0, 10'h006, 9'h000);
    check("pseudo b read", 32'(b_read_data), 32'h077);
  endtask

  // Queue with FULL 4, AFULL 3, AEMPTY 1; write code 101, read code 110.
  task automatic t_queue();
    logic [8:0] q;
    @(posedge sys_clk);
    {full_cascade_in, write_port_select} <= 3'b101;
    {empty_cascade_in, read_port_select} <= 3'b110;
    reg_wr(OFS_CONFIG, 32'h0000_0353);
    reg_wr(OFS_FULL, 32'h0);
    rd_chk("full clamp", OFS_FULL, 32'h1);
    reg_wr(OFS_FULL, 32'h4);
    reg_wr(OFS_AFULL, 32'h0);
    rd_chk("afull low", OFS_AFULL, 32'h1);
    reg_wr(OFS_AFULL, 32'h3FF);
    rd_chk("afull high", OFS_AFULL, 32'h3);
    reg_wr(OFS_AEMPTY, 32'h3FF);
    rd_chk("aempty high", OFS_AEMPTY, 32'h3);
    reg_wr(OFS_AEMPTY, 32'h1);
    for (int i = 1; i <= 5; i++) begin
      u_user.push(1'b1, 1'b1, 9'(9'h100 + i));
      check("near full", 32'(near_full_flag), 32'(i >= 3));
      check("full", 32'(full_flag), 32'(i >= 4));
      check("empty lags", 32'(empty_flag), 32'h1);
    end
    occ_chk(11'd4);
    for (int i = 1; i <= 5; i++) begin
      u_user.pop(1'b1, 1'b1, q);
      check("order", 32'(q), 32'(9'h100 + ((i > 4) ? 4 : i)));
      check("near empty", 32'(near_empty_flag), 32'(i >= 3));
      check("empty", 32'(empty_flag), 32'(i >= 4));
    end
    @(posedge sys_clk);
    full_cascade_in <= 1'b0;
    u_user.push(1'b1, 1'b1, 9'h0AB);
    occ_chk(11'd0);
    @(posedge sys_clk);
    full_cascade_in <= 1'b1;
    u_user.push(1'b0, 1'b1, 9'h0AB);
    occ_chk(11'd0);
    u_user.push(1'b1, 1'b1, 9'h011);
    u_user.push(1'b1, 1'b1, 9'h022);
    @(posedge sys_clk);
    empty_cascade_in <= 1'b0;
    u_user.pop(1'b1, 1'b1, q);
    occ_chk(11'd2);
    @(posedge sys_clk);
    empty_cascade_in <= 1'b1;
    u_user.pop(1'b0, 1'b1, q);
    occ_chk(11'd2);
    u_user.pop(1'b1, 1'b1, q);
    check("after skips", 32'(q), 32'h011);
    @(posedge sys_clk);
    read_pointer_clear <= 1'b1;
    @(posedge sys_clk);
    read_pointer_clear <= 1'b0;
    u_user.pop(1'b1, 1'b1, q);
    check("rp clear", 32'(q), 32'h101);
    u_user.push(1'b1, 1'b1, 9'h0CC);
    check("full again", 32'(full_flag), 32'h1);
    @(posedge sys_clk);
    queue_reset <= 1'b1;
    @(posedge sys_clk);
    queue_reset <= 1'b0;
    @(negedge sys_clk);
    check("reset flags", 32'({full_flag, near_full_flag, empty_flag, near_empty_flag}),
          32'h3);
    occ_chk(11'd0);
  endtask

  // Reset for twelve cycles, then run every scenario.
  initial begin
    {sys_clk, nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {a_select, a_clock_enable, a_write_enable, a_address, a_write_data} = '0;
    {b_select, b_clock_enable, b_write_enable, b_address, b_write_data} = '0;
    {write_port_select, full_cascade_in, read_port_select, empty_cascade_in} = '0;
    {queue_reset, read_pointer_clear, miscompares, cmp_count, cycles} = '0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_ram();
    t_queue();
    close_out();
  end
endmodule // embedded_block_memory_tb

// *** tb/queue_user_model.sv ***
`timescale 1ns/1ps
// Far-side user logic that drives the queue write and read ports.
module queue_user_model
  import embedded_block_memory_pkg::*;
(
  input  wire logic              sys_clk,
  output logic                   write_port_clock,
  output logic                   write_clock_enable,
  output logic                   write_enable,
  output logic      [DATA_W-1:0] queue_write_data,
  output logic                   read_port_clock,
  output logic                   read_clock_enable,
  output logic                   read_strobe,
  input  wire logic [DATA_W-1:0] queue_read_data
);
  // Port clocks stand still low outside a transfer; released data shows the inverse value.
  initial begin
    write_port_clock   = 1'b0;
    write_clock_enable = 1'b0;
    write_enable       = 1'b0;
    queue_write_data   = 9'h1FF;
    read_port_clock    = 1'b0;
    read_clock_enable  = 1'b0;
    read_strobe        = 1'b0;
  end

  // One write port clock event; the clock stays low a full cycle afterwards.
  task automatic push(input logic ce, input logic we, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    write_port_clock   <= 1'b1;
    write_clock_enable <= ce;
    write_enable       <= we;
    queue_write_data   <= d;
    @(posedge sys_clk);
    write_port_clock   <= 1'b0;
    write_clock_enable <= 1'b0;
    write_enable       <= 1'b0;
    queue_write_data   <= ~d;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // One read port clock event; the word is taken once the output has settled.
  task automatic pop(input logic ce, input logic re, output logic [DATA_W-1:0] q);
    @(posedge sys_clk);
    read_port_clock   <= 1'b1;
    read_clock_enable <= ce;
    read_strobe       <= re;
    @(posedge sys_clk);
    read_port_clock   <= 1'b0;
    read_clock_enable <= 1'b0;
    read_strobe       <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    q = queue_read_data;
  endtask
endmodule // queue_user_model
